// >>> src/upc_pkg.sv
// Shared constants and types for the USB clock synthesiser control registers
package upc_pkg;
    // Special-function register addresses
    localparam logic [7:0] UPC_CTRL_ADDR = 8'hA3;
    localparam logic [7:0] UPC_DIV_ADDR = 8'hA4;
    // Reset values of both registers
    localparam logic [7:0] UPC_CTRL_RESET = 8'h00;
    localparam logic [7:0] UPC_DIV_RESET = 8'h00;
    // Bit positions inside the control register
    localparam int UPC_BYPASS_BIT = 2;
    localparam int UPC_ENABLE_BIT = 1;
    localparam int UPC_LOCK_BIT = 0;
    // Reserved upper field of the control register
    localparam int UPC_RSVD_MSB = 7;
    localparam int UPC_RSVD_LSB = 3;
    localparam logic [4:0] UPC_RSVD_VAL = 5'h00;
    // Divider field layout
    localparam int UPC_DIV_W = 4;
    localparam int UPC_FB_LSB = 4;
    localparam int UPC_REF_LSB = 0;
    localparam logic [3:0] UPC_FIELD_RESET = 4'h0;
    // Clock period and lock settling time
    localparam int UPC_CLK_PERIOD_PS = 5000;
    localparam int UPC_LOCK_SETTLE_NS = 100;
    // Least time, so round up to whole cycles
    localparam int UPC_LOCK_SETTLE_CYC =
        (UPC_LOCK_SETTLE_NS * 1000 + UPC_CLK_PERIOD_PS - 1) / UPC_CLK_PERIOD_PS;
    // Lock qualifier states, Gray coded along off -> settle -> locked
    typedef enum logic [1:0] {
        UPC_LK_OFF = 2'b00,
        UPC_LK_SETTLE = 2'b01,
        UPC_LK_LOCKED = 2'b11
    } upc_lock_state_e;
endpackage : upc_pkg

// >>> src/upc_lock_qual.sv
// Lock qualifier: turns the raw analogue lock level into the lock flag
module upc_lock_qual #(
    parameter int SETTLE_CYC = upc_pkg::UPC_LOCK_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic synth_enable,
    input wire logic lock_raw,
    output logic lock_flag
);
    import upc_pkg::*;

    // Counter wide enough for the settle count
    localparam int CW = $clog2(SETTLE_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(SETTLE_CYC - 1);

    upc_lock_state_e state_q; // Qualifier state
    logic [CW-1:0] cnt_q; // Cycles of steady lock seen so far

    // State and settle counter; any loss of lock or enable restarts the wait
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= UPC_LK_OFF;
            cnt_q <= '0;
        end else if (!synth_enable || !lock_raw) begin
            state_q <= UPC_LK_OFF;
            cnt_q <= '0;
        end else begin
            case (state_q)
                UPC_LK_OFF: begin
                    state_q <= UPC_LK_SETTLE;
                    cnt_q <= '0;
                end
                UPC_LK_SETTLE: begin
                    // Lock must hold for the whole settle time
                    if (cnt_q == LAST) begin
                        state_q <= UPC_LK_LOCKED;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= UPC_LK_LOCKED;
                end
            endcase
        end
    end

    // Flag set only after settling, dropped one cycle after unlock or disable
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lock_flag <= 1'b0;
        end else begin
            lock_flag <= synth_enable && lock_raw &&
                ((state_q == UPC_LK_SETTLE && cnt_q == LAST) || state_q == UPC_LK_LOCKED);
        end
    end
endmodule : upc_lock_qual

// >>> src/upc_pll_regs.sv
// USB clock synthesiser control and divider registers on the SFR port
module upc_pll_regs #(
    parameter int SETTLE_CYC = upc_pkg::UPC_LOCK_SETTLE_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic synth_lock_raw,
    output logic ext_clock_bypass,
    output logic osc_enable,
    output logic synth_enable,
    output logic [upc_pkg::UPC_DIV_W-1:0] feedback_divider,
    output logic [upc_pkg::UPC_DIV_W-1:0] reference_divider,
    output logic synth_lock_flag
);
    import upc_pkg::*;

    logic ctrl_wr; // Write strobe decoded for the control register
    logic div_wr; // Write strobe decoded for the divider register
    logic [7:0] rd_mux; // Read value before the output register

    // Address decoding shared by write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] base);
        hit = (a == base);
    endfunction : hit

    assign ctrl_wr = sfr_wr && hit(sfr_addr, UPC_CTRL_ADDR);
    assign div_wr = sfr_wr && hit(sfr_addr, UPC_DIV_ADDR);

    // Clock source select; oscillator enable kept as its own flop so the
    // pin comes straight from a register yet always opposes the bypass
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_clock_bypass <= UPC_CTRL_RESET[UPC_BYPASS_BIT];
            osc_enable <= !UPC_CTRL_RESET[UPC_BYPASS_BIT];
        end else if (ctrl_wr) begin
            ext_clock_bypass <= sfr_wdata[UPC_BYPASS_BIT];
            osc_enable <= !sfr_wdata[UPC_BYPASS_BIT];
        end
    end

    // Synthesiser enable; the lock bit and reserved bits of a write are dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            synth_enable <= UPC_CTRL_RESET[UPC_ENABLE_BIT];
        end else if (ctrl_wr) begin
            synth_enable <= sfr_wdata[UPC_ENABLE_BIT];
        end
    end

    // Divider fields, driven straight to the analogue loop dividers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            feedback_divider <= UPC_DIV_RESET[UPC_FB_LSB +: UPC_DIV_W];
            reference_divider <= UPC_DIV_RESET[UPC_REF_LSB +: UPC_DIV_W];
        end else if (div_wr) begin
            feedback_divider <= sfr_wdata[UPC_FB_LSB +: UPC_DIV_W];
            reference_divider <= sfr_wdata[UPC_REF_LSB +: UPC_DIV_W];
        end
    end

    // Lock qualification; the raw level glitches while the loop slews,
    // so the flag waits for a steady lock at the cost of a short delay
    // hardware owned lock
    upc_lock_qual #(
        .SETTLE_CYC(SETTLE_CYC)
    ) u_lock (
        .clk_sys(clk_sys),
        .rst(rst),
        .synth_enable(synth_enable),
        .lock_raw(synth_lock_raw),
        .lock_flag(synth_lock_flag)
    );

    // Read multiplexer; unmapped addresses read as zero
    always_comb begin
        rd_mux = 8'h00;
        if (hit(sfr_addr, UPC_CTRL_ADDR)) begin
            rd_mux[UPC_RSVD_MSB:UPC_RSVD_LSB] = UPC_RSVD_VAL;
            rd_mux[UPC_BYPASS_BIT] = ext_clock_bypass;
            rd_mux[UPC_ENABLE_BIT] = synth_enable;
            rd_mux[UPC_LOCK_BIT] = synth_lock_flag;
        end else if (hit(sfr_addr, UPC_DIV_ADDR)) begin
            rd_mux[UPC_FB_LSB +: UPC_DIV_W] = feedback_divider;
            rd_mux[UPC_REF_LSB +: UPC_DIV_W] = reference_divider;
        end
    end

    // Read data register; holds its value between reads
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            sfr_rdata <= rd_mux;
        end
    end

    // Named steps used by the checks below
    sequence s_ctrl_wr;
        sfr_wr && sfr_addr == UPC_CTRL_ADDR;
    endsequence

    sequence s_div_wr;
        sfr_wr && sfr_addr == UPC_DIV_ADDR;
    endsequence

    sequence s_ctrl_rd;
        sfr_rd && sfr_addr == UPC_CTRL_ADDR;
    endsequence

    property p_bypass_write;
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_wr |=> ext_clock_bypass == $past(sfr_wdata[UPC_BYPASS_BIT]);
    endproperty
    a_bypass_write: assert property (p_bypass_write)
        else $error("bypass bit did not follow control write");

    property p_osc_follows_bypass;
        @(posedge clk_sys) disable iff (rst)
        osc_enable == !ext_clock_bypass;
    endproperty
    a_osc_follows_bypass: assert property (p_osc_follows_bypass)
        else $error("oscillator enable does not oppose bypass");

    property p_enable_write;
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_wr |=> synth_enable == $past(sfr_wdata[UPC_ENABLE_BIT]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable bit did not follow control write");

    property p_lock_needs_raw;
        @(posedge clk_sys) disable iff (rst)
        synth_lock_flag |-> $past(synth_lock_raw) && $past(synth_enable);
    endproperty
    a_lock_needs_raw: assert property (p_lock_needs_raw)
        else $error("lock flag set without raw lock");

    property p_lock_read;
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_rd |=> sfr_rdata[UPC_LOCK_BIT] == $past(synth_lock_flag);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock bit read does not show the flag");

    property p_reserved_zero;
        @(posedge clk_sys) disable iff (rst)
        s_ctrl_rd |=> sfr_rdata[UPC_RSVD_MSB:UPC_RSVD_LSB] == UPC_RSVD_VAL;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved control bits read nonzero");

    property p_div_roundtrip;
        @(posedge clk_sys) disable iff (rst)
        s_div_wr ##1 (sfr_rd && !sfr_wr && sfr_addr == UPC_DIV_ADDR)
            |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_div_roundtrip: assert property (p_div_roundtrip)
        else $error("divider read does not return written byte");

    property p_reset_zero;
        @(posedge clk_sys) disable iff (rst)
        $past(rst) |-> !synth_enable && !ext_clock_bypass && osc_enable
            && feedback_divider == UPC_FIELD_RESET && reference_divider == UPC_FIELD_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("registers not cleared after reset");

    property p_div_outputs;
        @(posedge clk_sys) disable iff (rst)
        s_div_wr |=> feedback_divider == $past(sfr_wdata[7:4])
            && reference_divider == $past(sfr_wdata[3:0]);
    endproperty
    a_div_outputs: assert property (p_div_outputs)
        else $error("divider outputs do not follow written fields");

    property p_disable_drops_lock;
        @(posedge clk_sys) disable iff (rst)
        $fell(synth_enable) |-> ##[0:1] !synth_lock_flag;
    endproperty
    a_disable_drops_lock: assert property (p_disable_drops_lock)
        else $error("lock flag stayed set after disable");
endmodule : upc_pll_regs

// >>> test/upc_loop_model.sv
// Behavioural analogue loop that reports raw lock after settling
module upc_loop_model #(
    parameter int LOCK_CYC = 4
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic synth_enable,
    input wire logic lose_lock,
    output logic synth_lock_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q; // Enabled cycles spent settling
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= 0;
        end else if (!synth_enable || lose_lock) begin
            // Stopped or disturbed loop starts over
            cnt_q <= 0;
        end else if (cnt_q < LOCK_CYC) begin
            cnt_q <= cnt_q + 1;
        end
    end
    // Raw lock only once fully settled
    assign synth_lock_raw = (cnt_q == LOCK_CYC);
endmodule : upc_loop_model

// >>> test/usb_pll_control_regs_tb.sv
// Self-checking bench for the synthesiser control registers
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module usb_pll_control_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import upc_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic lose_lock = 1'b0; // Bench disturbs the loop
    logic [7:0] sfr_rdata, rd_v;
    logic synth_lock_raw, ext_clock_bypass, osc_enable, synth_enable, synth_lock_flag;
    logic [3:0] feedback_divider, reference_divider;
    int n_errors = 0;
    int n_tests = 0;
    upc_pll_regs #(.SETTLE_CYC(2)) dut_u (.clk_sys(clk_sys), .rst(rst),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .synth_lock_raw(synth_lock_raw),
        .ext_clock_bypass(ext_clock_bypass), .osc_enable(osc_enable),
        .synth_enable(synth_enable), .feedback_divider(feedback_divider),
        .reference_divider(reference_divider), .synth_lock_flag(synth_lock_flag));
    upc_loop_model loop_u (.clk_sys(clk_sys), .rst(rst), .synth_enable(synth_enable),
        .lose_lock(lose_lock), .synth_lock_raw(synth_lock_raw));
    // 200 MHz system clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    // Prints counts and verdict, then stops
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // One-cycle write strobe; callers keep reserved bits zero
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        #1;
    endtask : wr
    // One-cycle read strobe, data taken after the answering edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clk_sys);
        sfr_rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask : rd
    // Bounded wait for the lock flag to reach a level
    task automatic wait_flag(input logic v, input int n);
        for (int i = 0; i < n; i++) begin
            if (synth_lock_flag === v) return;
            @(posedge clk_sys);
            #1;
        end
        n_errors++;
        $display("[FAIL] %0t lock flag wait ran out", $time);
        conclude();
    endtask : wait_flag
    // Reset values of registers and pins
    task automatic t_reset;
        `CHK({ext_clock_bypass, osc_enable, synth_enable, synth_lock_flag}, 4'h4)
        rd(UPC_CTRL_ADDR, rd_v);
        `CHK(rd_v, UPC_CTRL_RESET)
        rd(UPC_DIV_ADDR, rd_v);
        `CHK(rd_v, UPC_DIV_RESET)
    endtask : t_reset
    // Bypass and enable controls, lock bit not writable
    task automatic t_ctrl;
        wr(UPC_CTRL_ADDR, 8'h05);
        `CHK({ext_clock_bypass, osc_enable, synth_enable}, 3'h4)
        rd(UPC_CTRL_ADDR, rd_v);
        `CHK(rd_v, 8'h04)
        wr(UPC_CTRL_ADDR, 8'h06);
        `CHK({ext_clock_bypass, osc_enable, synth_enable}, 3'h5)
        wr(UPC_CTRL_ADDR, 8'h00);
        `CHK({ext_clock_bypass, osc_enable, synth_enable}, 3'h2)
    endtask : t_ctrl
    // Divider fields and an unmapped address
    task automatic t_div;
        wr(UPC_DIV_ADDR, 8'h30);
        `CHK({feedback_divider, reference_divider}, 8'h30)
        wr(UPC_DIV_ADDR, 8'hB9);
        wr(8'hA5, 8'h5A);
        `CHK({feedback_divider, reference_divider}, 8'hB9)
        rd(UPC_DIV_ADDR, rd_v);
        `CHK(rd_v, 8'hB9)
        rd(8'hA5, rd_v);
        `CHK(rd_v, 8'h00)
    endtask : t_div
    // Write then read on the next edge, a read that meets a write, held read data
    task automatic t_b2b;
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_addr <= UPC_DIV_ADDR;
        sfr_wdata <= 8'h21;
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b1;
        @(posedge clk_sys);
        sfr_wr <= 1'b1;
        sfr_wdata <= 8'h50;
        #1;
        `CHK(sfr_rdata, 8'h21)
        @(posedge clk_sys);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        #1;
        `CHK(sfr_rdata, 8'h21)
        `CHK({feedback_divider, reference_divider}, 8'h50)
        @(posedge clk_sys);
        #1;
        `CHK(sfr_rdata, 8'h21)
    endtask : t_b2b
    // Lock rises, drops on loss and on disable
    task automatic t_lock;
        wr(UPC_CTRL_ADDR, 8'h02);
        wait_flag(1'b1, 20);
        rd(UPC_CTRL_ADDR, rd_v);
        `CHK(rd_v, 8'h03)
        @(posedge clk_sys);
        lose_lock <= 1'b1;
        wait_flag(1'b0, 3);
        @(posedge clk_sys);
        lose_lock <= 1'b0;
        wait_flag(1'b1, 20);
        wr(UPC_CTRL_ADDR, 8'h00);
        wait_flag(1'b0, 2);
        rd(UPC_CTRL_ADDR, rd_v);
        `CHK(rd_v, 8'h00)
    endtask : t_lock
    // Reset in mid-run clears everything again
    task automatic t_rerun;
        wr(UPC_CTRL_ADDR, 8'h06);
        wr(UPC_DIV_ADDR, 8'h72);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        `CHK({feedback_divider, reference_divider, synth_enable}, 9'h000)
        t_reset();
    endtask : t_rerun
    // Main sequence
    initial begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        t_reset();
        t_ctrl();
        t_div();
        t_b2b();
        t_lock();
        t_rerun();
        conclude();
    end
endmodule : usb_pll_control_regs_tb
